// ==== hw/adc_serial_output_port.sv ====
// Serial output port of the ADC: self-clocked and host-clocked shifting.
`timescale 1ns/10ps
`include "adc_port_defines.svh"

// Function
// - Mode pin high selects self-clocked shifting.
// - Mode pin low selects host-clocked shifting.
// - Interval is sixteen periods of 64 clocks.
// - Poll select at digital period start, then send.
// - Self-clocked output only in digital periods.
// - After LSB, ready high until new word.
// - Select rising: finish bit, then float outputs.
// - Resume with next bit next digital period.
// - Unsent word replaced: ready high four clocks.
// - Data changes on own shift clock fall.
// - Select falling presents MSB before clock edges.
// - Host drives clock; advance on falling edge.
// - Host mode: float ready and data after LSB.
// - Host mode: busy transfer discards new word.
// - Host mode: select high floats, resume same bit.
// - Host mode, select high: ready pulse, reload.
// - Standby low floats clock and data, halts all else but pin sync, host edge tracking and self-mode ready enable.
module adc_serial_output_port (
  input  wire logic               i_clk_sys,
  input  wire logic               i_srst,
  input  wire logic               i_mode,
  input  wire logic               i_select_n,
  input  wire logic               i_standby_n,
  input  wire logic               i_sclk,
  input  wire adc_port_pkg::word_t i_word,
  input  wire logic               i_word_valid,
  output logic                    o_sclk,
  output logic                    o_sclk_oe,
  output logic                    o_serial_out,
  output logic                    o_serial_out_oe,
  output logic                    o_word_ready_n,
  output logic                    o_word_ready_n_oe
);
  import adc_port_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`SYNC_W-1:0]   pin_s1;
  logic [`SYNC_W-1:0]   pin_s2;
  gray_t                gray_s1;
  gray_t                gray_s2;
  gray_t                seen_bin;
  logic [`SLOT_W-1:0]   slot_cnt;
  word_t                word;
  word_t                pend_word;
  bit_idx_t             bit_idx;
  logic                 loaded;
  load_state_t          ld_state;
  logic [`LD_CNT_W-1:0] ld_cnt;
  shift_state_t         sc_state;
  logic [`SC_CNT_W-1:0] sc_cnt;

  logic                 mode_self;
  logic                 sel_n;
  logic                 awake;
  logic [`PHASE_W-1:0]  phase;
  logic                 digital;
  logic                 poll;
  logic                 done;
  logic                 host_busy;
  logic                 sending_host;
  logic                 host_edge;
  logic                 word_in;
  logic                 load_now;
  logic                 pulse_start;
  logic                 pulse_load;
  logic                 any_load;
  logic                 sc_start;
  logic                 sc_bit_end;
  logic                 sc_more;
  logic                 advance;
  bit_idx_t             next_idx;

  link_count_if link_cnt ();

  link_edge_counter u_link (
    .i_sclk (i_sclk),
    .cnt    (link_cnt.counter)
  );

  // ----------------------------------------------------------------
  // Pin and link crossings
  // ----------------------------------------------------------------
  // Mode, select and standby are pins; the edge count is a gray pointer
  // that moves one step per host clock, far slower than this clock.
  always_ff @(posedge i_clk_sys) begin
    pin_s1  <= {i_mode, i_select_n, i_standby_n};
    pin_s2  <= pin_s1;
    gray_s1 <= link_cnt.gray;
    gray_s2 <= gray_s1;
  end

  assign mode_self = pin_s2[2];
  assign sel_n     = pin_s2[1];
  assign awake     = pin_s2[0];

  // ----------------------------------------------------------------
  // Sampling interval framing
  // ----------------------------------------------------------------
  // The counter wraps after sixteen periods of 64 clocks.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      slot_cnt <= '0;
    end else if (awake) begin
      slot_cnt <= slot_cnt + 1'b1;
    end
  end

  assign phase   = slot_cnt[`PHASE_MSB:`PHASE_LSB];
  assign digital = slot_cnt[`DIGITAL_BIT];
  assign poll    = awake && digital && (phase == '0);

  // ----------------------------------------------------------------
  // Transfer conditions
  // ----------------------------------------------------------------
  assign done         = (bit_idx == `WORD_DONE_IDX);
  assign next_idx     = bit_idx + 1'b1;
  assign host_busy    = !mode_self && !sel_n && loaded && !done;
  assign sending_host = host_busy && awake;
  assign host_edge    = (seen_bin != gray_to_bin(gray_s2));
  assign word_in      = i_word_valid && awake && (ld_state == LD_IDLE);
  assign load_now     = word_in && !host_busy && (done || !loaded);
  assign pulse_start  = word_in && !host_busy && loaded && !done;
  assign pulse_load   = (ld_state == LD_PULSE) && awake && (ld_cnt == `LD_LAST);
  assign any_load     = load_now || pulse_load;
  assign sc_start     = mode_self && poll && !sel_n && loaded && !done &&
                        (ld_state == LD_IDLE) && !pulse_start;
  assign sc_bit_end   = awake && (sc_state == SC_HIGH) && (sc_cnt == `SC_HALF_LAST);
  // A further bit must still end inside the current digital period.
  assign sc_more      = mode_self && !sel_n && digital && (bit_idx != `WORD_LAST_IDX) &&
                        (phase <= `LAST_BIT_START) && (ld_state == LD_IDLE) &&
                        !pulse_start;
  assign advance      = (mode_self && sc_bit_end) || (sending_host && host_edge);

  // ----------------------------------------------------------------
  // Host clock edge tracking
  // ----------------------------------------------------------------
  // One edge is taken per cycle, so a burst of steps is never lost.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      seen_bin <= gray_to_bin(gray_s2);
    end else if (host_edge) begin
      seen_bin <= seen_bin + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Replacement word sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ld_state  <= LD_IDLE;
      ld_cnt    <= '0;
      pend_word <= '0;
    end else begin
      case (ld_state)
        LD_IDLE: begin
          if (pulse_start) begin
            ld_state  <= LD_PULSE;
            ld_cnt    <= '0;
            pend_word <= i_word;
          end
        end
        LD_PULSE: begin
          if (awake) begin
            ld_cnt <= ld_cnt + 1'b1;
            if (ld_cnt == `LD_LAST) begin
              ld_state <= LD_IDLE;
            end
          end
        end
        default: begin
          ld_state <= LD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output word, bit position and word-ready flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      word              <= '0;
      bit_idx           <= '0;
      loaded            <= 1'b0;
      o_word_ready_n    <= 1'b1;
      o_word_ready_n_oe <= 1'b1;
    end else begin
      if (mode_self) begin
        o_word_ready_n_oe <= 1'b1;
      end
      if (any_load) begin
        word              <= load_now ? i_word : pend_word;
        bit_idx           <= '0;
        loaded            <= 1'b1;
        o_word_ready_n    <= 1'b0;
        o_word_ready_n_oe <= 1'b1;
      end else if (pulse_start) begin
        o_word_ready_n    <= 1'b1;
      end else if (advance) begin
        bit_idx <= next_idx;
        if (bit_idx == `WORD_LAST_IDX) begin
          o_word_ready_n    <= 1'b1;
          o_word_ready_n_oe <= mode_self;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift clock and serial data
  // ----------------------------------------------------------------
  // Self-clocked bits are driven here; in host mode the same register
  // follows the bit position, so the MSB is out before any host edge.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sc_state        <= SC_IDLE;
      sc_cnt          <= '0;
      o_sclk          <= 1'b1;
      o_sclk_oe       <= 1'b0;
      o_serial_out    <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else if (!awake) begin
      sc_state        <= SC_IDLE;
      sc_cnt          <= '0;
      o_sclk          <= 1'b1;
      o_sclk_oe       <= 1'b0;
      o_serial_out_oe <= 1'b0;
    end else if (mode_self) begin
      case (sc_state)
        SC_IDLE: begin
          sc_cnt <= '0;
          o_sclk <= 1'b1;
          if (sc_start) begin
            sc_state        <= SC_LOW;
            o_sclk          <= 1'b0;
            o_sclk_oe       <= 1'b1;
            o_serial_out    <= word_bit(word, bit_idx);
            o_serial_out_oe <= 1'b1;
          end else begin
            o_sclk_oe       <= 1'b0;
            o_serial_out_oe <= 1'b0;
          end
        end
        SC_LOW: begin
          sc_cnt <= sc_cnt + 1'b1;
          if (sc_cnt == `SC_HALF_LAST) begin
            sc_state <= SC_HIGH;
            sc_cnt   <= '0;
            o_sclk   <= 1'b1;
          end
        end
        SC_HIGH: begin
          sc_cnt <= sc_cnt + 1'b1;
          if (sc_cnt == `SC_HALF_LAST) begin
            sc_cnt <= '0;
            if (sc_more) begin
              sc_state     <= SC_LOW;
              o_sclk       <= 1'b0;
              o_serial_out <= word_bit(word, next_idx);
            end else begin
              sc_state        <= SC_IDLE;
              o_sclk_oe       <= 1'b0;
              o_serial_out_oe <= 1'b0;
            end
          end
        end
        default: begin
          sc_state <= SC_IDLE;
        end
      endcase
    end else begin
      sc_state        <= SC_IDLE;
      sc_cnt          <= '0;
      o_sclk          <= 1'b1;
      o_sclk_oe       <= 1'b0;
      o_serial_out    <= word_bit(word, bit_idx);
      o_serial_out_oe <= sending_host;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ready_pulse;
    @(posedge i_clk_sys) disable iff (i_srst || !awake)
      pulse_start |=> o_word_ready_n [*4] ##1 !o_word_ready_n;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse not four clocks");

  property p_done_ready;
    @(posedge i_clk_sys) disable iff (i_srst)
      (advance && bit_idx == `WORD_LAST_IDX && !any_load && !pulse_start) |=> (o_word_ready_n && done);
  endproperty
  a_done_ready: assert property (p_done_ready) else $error("ready not high after last bit");

  property p_host_float;
    @(posedge i_clk_sys) disable iff (i_srst)
      (!mode_self && advance && bit_idx == `WORD_LAST_IDX) |=> !o_word_ready_n_oe ##1 !o_serial_out_oe;
  endproperty
  a_host_float: assert property (p_host_float) else $error("host mode outputs not floated");

  property p_self_digital;
    @(posedge i_clk_sys) disable iff (i_srst)
      (sc_state != SC_IDLE) |-> digital;
  endproperty
  a_self_digital: assert property (p_self_digital) else $error("shifting outside digital period");

  property p_sc_start;
    @(posedge i_clk_sys) disable iff (i_srst || !awake)
      sc_start |=> (o_sclk_oe && !o_sclk && o_serial_out_oe);
  endproperty
  a_sc_start: assert property (p_sc_start) else $error("polled start did not drive outputs");

  property p_sclk_shape;
    @(posedge i_clk_sys) disable iff (i_srst || !awake)
      sc_start |=> !o_sclk [*2] ##1 o_sclk [*2];
  endproperty
  a_sclk_shape: assert property (p_sclk_shape) else $error("shift clock bit shape wrong");

  property p_sel_float;
    @(posedge i_clk_sys) disable iff (i_srst)
      (mode_self && sc_bit_end && sel_n) |=> (!o_sclk_oe && !o_serial_out_oe);
  endproperty
  a_sel_float: assert property (p_sel_float) else $error("outputs not floated after select rise");

  property p_host_discard;
    @(posedge i_clk_sys) disable iff (i_srst)
      (word_in && host_busy) |=> $stable(word);
  endproperty
  a_host_discard: assert property (p_host_discard) else $error("busy transfer word replaced");

  property p_host_sel_float;
    @(posedge i_clk_sys) disable iff (i_srst)
      (!mode_self && sel_n) |=> !o_serial_out_oe;
  endproperty
  a_host_sel_float: assert property (p_host_sel_float) else $error("data driven with select high");

  property p_host_advance;
    @(posedge i_clk_sys) disable iff (i_srst)
      (sending_host && host_edge) |=> (bit_idx == $past(next_idx));
  endproperty
  a_host_advance: assert property (p_host_advance) else $error("host edge did not advance bit");

  property p_standby;
    @(posedge i_clk_sys) disable iff (i_srst)
      !awake |=> (!o_sclk_oe && !o_serial_out_oe && $stable(slot_cnt));
  endproperty
  a_standby: assert property (p_standby) else $error("activity during standby");

  property p_ready_load;
    @(posedge i_clk_sys) disable iff (i_srst)
      any_load |=> (!o_word_ready_n && o_word_ready_n_oe);
  endproperty
  a_ready_load: assert property (p_ready_load) else $error("ready not low after load");
endmodule : adc_serial_output_port

// ==== hw/adc_port_defines.svh ====
// Shared constants of the ADC serial output port.
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// Sampling interval framing, in master clocks.
`define PERIOD_CLKS      64
`define PERIODS_PER_SAMP 16
`define SLOT_W           10
`define PHASE_W          6
`define PHASE_MSB        5
`define PHASE_LSB        0
// Odd periods are digital computation periods, even ones analog settling.
`define DIGITAL_BIT      6

// Output word.
`define WORD_BITS        20
`define IDX_W            5
`define WORD_LAST_IDX    5'h13
`define WORD_DONE_IDX    5'h14

// Word-ready high pulse before a replacement word loads.
`define READY_HIGH_CLKS  4
`define LD_CNT_W         3
`define LD_LAST          3'(`READY_HIGH_CLKS - 1)

// Self-clocked shift clock: low half then high half per bit.
`define SCLK_HALF_CLKS   2
`define SC_CNT_W         2
`define SC_HALF_LAST     2'(`SCLK_HALF_CLKS - 1)
`define LAST_BIT_START   6'(`PERIOD_CLKS - 2 * `SCLK_HALF_CLKS - 1)

// Crossing widths.
`define GRAY_W           6
`define SYNC_W           3

`endif

// ==== hw/adc_port_pkg.sv ====
// Types and helper functions of the ADC serial output port.
`include "adc_port_defines.svh"
package adc_port_pkg;
  typedef logic [`WORD_BITS-1:0] word_t;
  typedef logic [`IDX_W-1:0]     bit_idx_t;
  typedef logic [`GRAY_W-1:0]    gray_t;
  typedef enum logic [1:0] {SC_IDLE, SC_LOW, SC_HIGH} shift_state_t;
  typedef enum logic {LD_IDLE, LD_PULSE} load_state_t;

  function automatic gray_t bin_to_gray(input gray_t b);
    return b ^ (b >> 1);
  endfunction : bin_to_gray

  function automatic gray_t gray_to_bin(input gray_t g);
    gray_t b;
    b = g;
    for (int i = `GRAY_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  // Bit idx counted from the MSB; past the LSB it reads as zero.
  function automatic logic word_bit(input word_t w, input bit_idx_t idx);
    logic r;
    r = 1'b0;
    for (int i = 0; i < `WORD_BITS; i++) begin
      if (idx == `IDX_W'(i)) begin
        r = w[`WORD_BITS-1-i];
      end
    end
    return r;
  endfunction : word_bit
endpackage : adc_port_pkg

// ==== hw/link_count_if.sv ====
// Gray-coded count of host shift clock falling edges.
`timescale 1ns/10ps
interface link_count_if;
  import adc_port_pkg::*;
  gray_t gray;
  modport counter (output gray);
  modport reader  (input  gray);
endinterface : link_count_if

// ==== hw/link_edge_counter.sv ====
// Counts falling edges of the host shift clock in its own domain.
`timescale 1ns/10ps
module link_edge_counter (
  input wire logic      i_sclk,
  link_count_if.counter cnt
);
  import adc_port_pkg::*;

  // The host clock may stand still during reset, so the counter holds a
  // power-up value; only differences are used on the far side.
  gray_t edges = '0;
  gray_t gray  = '0;

  always_ff @(negedge i_sclk) begin
    edges <= edges + 1'b1;
    gray  <= bin_to_gray(edges + 1'b1);
  end

  assign cnt.gray = gray;
endmodule : link_edge_counter

// ==== tb/host_port_model.sv ====
// Host side model: supplies the host shift clock and captures serial bits.
`timescale 1ns/10ps
module host_port_model (
  input  wire logic       i_host_mode,
  input  wire logic       i_go,
  input  wire logic [4:0] i_edges,
  input  wire logic       i_sclk,
  input  wire logic       i_data,
  input  wire logic       i_clear,
  output logic            o_sclk,
  output logic            o_sclk_oe,
  output logic [19:0]     o_word,
  output logic [4:0]      o_bits
);
  // The clock rests high between frames, so no stray falling edge reaches the device.
  assign o_sclk_oe = i_host_mode;

  initial o_sclk = 1'h1;

  // The odd start offset keeps the link clock unrelated in phase to the master clock.
  // A real host would run the master clock from its own clock; the bench does not need to.
  always @(posedge i_go) begin
    #3.3;
    repeat (i_edges) begin
      #62.5 o_sclk = 1'h0;
      #62.5 o_sclk = 1'h1;
    end
  end

  // A host samples at the fall, before the device moves on; a shift register samples at the rise.
  always @(posedge i_clear or posedge i_sclk or negedge i_sclk) begin
    if (i_clear) begin
      o_word = '0;
      o_bits = '0;
    end else if (i_sclk !== i_host_mode) begin
      o_word = {o_word[18:0], i_data};
      o_bits = o_bits + 5'h01;
    end
  end
endmodule : host_port_model

// ==== tb/testbench.sv ====
// Self-checking testbench of the ADC serial output port.
`timescale 1ns/10ps
module testbench;
  import adc_port_pkg::*;
  typedef struct packed {logic m; word_t w; logic oe;} row_t;
  localparam word_t host_w = 20'h9a9c3;
  logic       clk, srst, mode, sel_n, stby_n, valid, clr, go, mon_on;
  logic       sclk_o, sclk_oe, dout, dout_oe, rdy_n, rdy_oe, h_sclk, h_oe;
  logic       sclk_w, data_w, sclk_last, data_last, p_out, p_oe, p_sclk;
  logic [4:0] edges, bits;
  logic [9:0] slot;
  word_t      word, cap;
  int         fail_count, check_count, cyc, n;
  row_t       rows [4] = '{'{1'h1, 20'ha5c3e, 1'h1}, '{1'h1, 20'h80001, 1'h1},
                           '{1'h0, 20'h5a5a5, 1'h0}, '{1'h0, 20'hfffff, 1'h0}};

  // A released line shows the inverse of its last level, never a lucky match.
  assign sclk_w = sclk_oe ? sclk_o : (h_oe ? h_sclk : ~sclk_last);
  assign data_w = dout_oe ? dout : ~data_last;

  adc_serial_output_port dut (.i_clk_sys(clk), .i_srst(srst), .i_mode(mode), .i_select_n(sel_n),
    .i_standby_n(stby_n), .i_sclk(sclk_w), .i_word(word), .i_word_valid(valid), .o_sclk(sclk_o),
    .o_sclk_oe(sclk_oe), .o_serial_out(dout), .o_serial_out_oe(dout_oe), .o_word_ready_n(rdy_n),
    .o_word_ready_n_oe(rdy_oe));
  host_port_model host (.i_host_mode(~mode), .i_go(go), .i_edges(edges), .i_sclk(sclk_w),
    .i_data(data_w), .i_clear(clr), .o_sclk(h_sclk), .o_sclk_oe(h_oe), .o_word(cap), .o_bits(bits));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checks and helpers
  // ---------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input word_t exp, input word_t got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic load(input word_t w);
    word <= w;
    valid <= 1'h1;
    tick(1);
    valid <= 1'h0;
  endtask : load

  task automatic send(input int k);
    edges <= 5'(k);
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
  endtask : send

  task automatic wait_bits(input int k);
    for (int i = 0; i < 4000 && bits < 5'(k); i++) tick(1);
  endtask : wait_bits

  task automatic wait_rdy();
    for (int i = 0; i < 8 && rdy_n !== 1'h0; i++) @(negedge clk);
    tick(1);
    chk_bit("ready_n after load", 1'h0, rdy_n);
  endtask : wait_rdy

  task automatic xfer(input word_t w);
    clr <= 1'h1;
    tick(1);
    clr <= 1'h0;
    sel_n <= 1'h0;
    tick(8);
    if (!mode) begin
      chk_bit("data_oe on select fall", 1'h1, dout_oe);
      chk_bit("msb before clock", w[19], data_w);
      send(20);
    end
    wait_bits(20);
    tick(8);
    chk_word("captured word", w, cap);
    sel_n <= 1'h1;
  endtask : xfer

  task automatic pulse(input word_t a, input word_t b);
    load(a);
    wait_rdy();
    load(b);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (rdy_n === 1'h1) n++;
      else if (n > 0) break;
    end
    tick(1);
    chk_word("ready high cycles", 20'h00004, 20'(n));
    xfer(b);
  endtask : pulse

  always @(posedge clk) begin
    cyc <= cyc + 1;
    slot <= srst ? 10'h000 : slot + 10'h001;
    p_out <= dout;
    p_oe <= dout_oe;
    p_sclk <= sclk_o;
    if (sclk_oe || h_oe) sclk_last <= sclk_w;
    if (dout_oe) data_last <= dout;
    if (mon_on && !slot[6] && slot[5:0] > 6'h03 && slot[5:0] < 6'h3c) chk_bit("settling sclk_oe", 1'h0, sclk_oe);
    if (mode && dout_oe && p_oe && !(p_sclk && !sclk_o)) chk_bit("data off fall", p_out, dout);
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    srst = 1'h1;
    mode = 1'h1;
    sel_n = 1'h1;
    stby_n = 1'h1;
    valid = 1'h0;
    word = '0;
    clr = 1'h1;
    go = 1'h0;
    edges = '0;
    sclk_last = 1'h1;
    data_last = 1'h0;
    mon_on = 1'h0;
    tick(10);
    srst <= 1'h0;
    clr <= 1'h0;
    tick(4);
    chk_bit("reset ready_n", 1'h1, rdy_n);
    chk_bit("reset ready_oe", 1'h1, rdy_oe);
    chk_bit("reset sclk_oe", 1'h0, sclk_oe);
    chk_bit("reset data_oe", 1'h0, dout_oe);
    $display("test reset done");
    mon_on <= 1'h1;
    foreach (rows[r]) begin
      mode <= rows[r].m;
      tick(6);
      load(rows[r].w);
      wait_rdy();
      xfer(rows[r].w);
      chk_bit("ready_oe after word", rows[r].oe, rdy_oe);
      if (mode) chk_bit("ready_n after word", 1'h1, rdy_n);
      else chk_bit("data_oe after word", 1'h0, dout_oe);
      $display("test row %0d done", r);
    end
    mode <= 1'h1;
    tick(6);
    clr <= 1'h1;
    load(20'h3c96a);
    clr <= 1'h0;
    sel_n <= 1'h0;
    wait_bits(3);
    sel_n <= 1'h1;
    tick(12);
    chk_bit("sclk_oe after select rise", 1'h0, sclk_oe);
    chk_bit("data_oe after select rise", 1'h0, dout_oe);
    chk_bit("bits after select rise", 1'h1, bits < 5'h05);
    sel_n <= 1'h0;
    wait_bits(20);
    tick(8);
    chk_word("resumed word", 20'h3c96a, cap);
    sel_n <= 1'h1;
    $display("test self interrupt done");
    for (int m = 1; m >= 0; m--) begin
      mode <= 1'(m);
      tick(6);
      pulse(20'h12345 + 20'(m), 20'hedcba - 20'(m));
      $display("test replacement mode %0d done", m);
    end
    clr <= 1'h1;
    load(host_w);
    clr <= 1'h0;
    sel_n <= 1'h0;
    tick(8);
    send(7);
    wait_bits(7);
    load(20'h00000);
    tick(20);
    sel_n <= 1'h1;
    tick(6);
    chk_bit("data_oe on select rise", 1'h0, dout_oe);
    sel_n <= 1'h0;
    tick(8);
    chk_bit("interrupted bit again", host_w[12], data_w);
    send(13);
    wait_bits(20);
    tick(8);
    chk_word("kept word", host_w, cap);
    sel_n <= 1'h1;
    $display("test host interrupt done");
    mode <= 1'h1;
    mon_on <= 1'h0;
    tick(6);
    load(20'h6e2f4);
    stby_n <= 1'h0;
    tick(4);
    sel_n <= 1'h0;
    n = 0;
    repeat (1100) begin
      tick(1);
      if (sclk_oe !== 1'h0) n++;
    end
    chk_word("clock cycles in standby", 20'h00000, 20'(n));
    stby_n <= 1'h1;
    tick(4);
    xfer(20'h6e2f4);
    $display("test standby done");
    results();
  end
endmodule : testbench
